// ### src/bridge_params.svh
// Constants for the H-bridge drive and protection block.
// Assumes a 20 MHz core clock and an AXI4-Lite register bus.
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define SHORT_OFF_DELAY_NS 1000
`define SHORT_OFF_CYCLES \
  (((`SHORT_OFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`SHORT_OFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define DEAD_CYCLES 2

`define CSR_ADDR 8'h21
`define CSR_RESET 8'h00
`define BIT_EN 0
`define BIT_PWMSEL 1
`define BIT_LEFT 2
`define BIT_RIGHT 3
`define BIT_DIR 4
`define BIT_SHORT 5
`define BIT_OVT 6
`define BIT_IRQEN 7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### src/bridge_pkg.sv
// Types shared by the H-bridge drive and protection block.
// Assumes bridge_params.svh supplies the numeric constants.
package bridge_pkg;
  typedef enum logic [2:0] {
    MODE_DIRECT = 3'b000,
    MODE_UP = 3'b001,
    MODE_DOWN = 3'b010,
    MODE_SYM = 3'b011,
    MODE_DUAL = 3'b100
  } drive_mode_t;

  typedef enum logic [1:0] {
    LEG_OFF = 2'b00,
    LEG_HIGH = 2'b01,
    LEG_LOW = 2'b10,
    LEG_WAIT = 2'b11
  } leg_state_t;
endpackage

// ### src/half_bridge_leg.sv
// One half bridge with break-before-make gate sequencing.
// Assumes the requested side arrives as a level; gate feedback is a level.
`timescale 1ns/1ps
`include "bridge_params.svh"

module half_bridge_leg
  import bridge_pkg::*;
#(
  parameter int DEAD = `DEAD_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Request
  input wire logic wantHigh,
  input wire logic wantLow,
  // Gate confirmation
  input wire logic highSeenOn,
  input wire logic lowSeenOn,
  // Gates
  output logic gateHigh,
  output logic gateLow
);
  import bridge_pkg::*;

  initial
  begin
    if (DEAD < 1 || DEAD > 255)
      $error("DEAD out of range");
  end

  typedef struct packed {
    leg_state_t st;
    logic [7:0] cnt;
  } leg_t;

  leg_t cur_reg, cur_next;

  // Switch only after the opposite gate is confirmed off plus a gap
  always_comb
  begin
    cur_next = cur_reg;
    case (cur_reg.st)
      LEG_OFF:
      begin
        if ((wantHigh && !lowSeenOn) || (wantLow && !highSeenOn))
        begin
          cur_next.st = LEG_WAIT;
          cur_next.cnt = 8'(DEAD);
        end
      end
      LEG_WAIT:
      begin
        if (!(wantHigh || wantLow))
          cur_next.st = LEG_OFF;
        else if (cur_reg.cnt > 8'h01)
          cur_next.cnt = cur_reg.cnt - 8'h01;
        else if (wantHigh && !lowSeenOn)
          cur_next.st = LEG_HIGH;
        else if (wantLow && !highSeenOn)
          cur_next.st = LEG_LOW;
      end
      LEG_HIGH:
      begin
        if (!wantHigh)
          cur_next.st = LEG_OFF;
      end
      LEG_LOW:
      begin
        if (!wantLow)
          cur_next.st = LEG_OFF;
      end
      default:
        cur_next.st = LEG_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  // Outputs drop at once when the request goes away
  assign gateHigh = (cur_reg.st == LEG_HIGH) && wantHigh;
  assign gateLow = (cur_reg.st == LEG_LOW) && wantLow;

  a_no_shoot: assert property (@(posedge mclk) disable iff (!reset_n)
    !(gateHigh && gateLow))
    else $error("both gates of one leg on");
endmodule

// ### src/hbridge_drive_protect.sv
// H-bridge control, PWM mode mux, short and overheat protection.
// Assumes synchronous detector inputs and an AXI4-Lite master.
//
// Operation
// - Enable clear forces all four gates low.
// - Enable resets to zero on any reset.
// - Short flag is the OR of four switch overcurrent detectors.
// - Short flag is set by hardware only, never by writes.
// - Overcurrent sets short flag; that switch turns off after a delay.
// - Bridge stays off while short flag is set.
// - Clearing enable clears short flag; re-enable retries.
// - Rising short flag raises interrupt when enabled.
// - Overheat sets overheat flag and turns all switches off.
// - Rising overheat flag raises interrupt when enabled.
// - Bridge stays off while overheat flag is set.
// - Overheat flag clears only by clearing enable.
// - Never both switches of a half bridge on; break before make.
// - Flags behave the same in any output state.
// - Enabling interrupts with a flag already set raises request.
// - Clearing enable clears the pending interrupt request.
// - Direct mode drives each half from its control bit.
// - Brake modes: PWM A switches one side, other side fixed.
// - Symmetrical mode: PWM A drives both sides complementary.
// - Dual mode: PWM A left half, PWM B right half.
// - Gate at 1 means switch on.
// - PWM select plus two control bits choose the drive mode.
// - Direction takes effect at next rising PWM edge only.
// - Control/status bit layout from bit 0; resets to zero.
`timescale 1ns/1ps
`include "bridge_params.svh"

module hbridge_drive_protect
  import bridge_pkg::*;
#(
  parameter int SHORT_OFF = `SHORT_OFF_CYCLES,
  parameter int DEAD = `DEAD_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // PWM generator lines
  input wire logic pwmLineA,
  input wire logic pwmLineB,
  // Protection inputs
  input wire logic [3:0] perSwitchOvercurrent,
  input wire logic overheatWarn,
  // Gate feedback, high when a gate is seen on
  input wire logic [3:0] gateSeenOn,
  // Gate drives
  output logic gateHighLeft,
  output logic gateLowLeft,
  output logic gateHighRight,
  output logic gateLowRight,
  // Interrupt request
  output logic faultIrq
);
  import bridge_pkg::*;

  initial
  begin
    if (SHORT_OFF < 1 || SHORT_OFF > 255)
      $error("SHORT_OFF out of range");
  end

  function automatic logic addrHit(input logic [31:0] a);
    return a[31:2] == 30'(`CSR_ADDR);
  endfunction

  typedef struct packed {
    logic enable;
    logic pwmSel;
    logic leftCtrl;
    logic rightCtrl;
    logic dirWritten;
    logic dirActive;
    logic shortFlag;
    logic overheatFlag;
    logic irqEnable;
    logic irq;
    logic pwmAPrev;
    logic pwmBPrev;
    logic [3:0] swOff;
    logic [3:0][7:0] ocCnt;
    logic awHeld;
    logic [31:0] awHeldAddr;
    logic wHeld;
    logic [31:0] wHeldData;
    logic [3:0] wHeldStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t cur_reg, cur_next;
  drive_mode_t mode;
  logic [3:0] want;
  logic [3:0] gates;
  logic [7:0] csrView;
  logic pwmRise;
  logic doWrite;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic enClear;
  logic anyOc;

  always_comb
  begin
    if (!cur_reg.pwmSel)
      mode = MODE_DIRECT;
    else
      case ({cur_reg.leftCtrl, cur_reg.rightCtrl})
        2'b00: mode = MODE_UP;
        2'b01: mode = MODE_DOWN;
        2'b10: mode = MODE_SYM;
        default: mode = MODE_DUAL;
      endcase
  end

  assign csrView = {cur_reg.irqEnable, cur_reg.overheatFlag,
                    cur_reg.shortFlag, cur_reg.dirWritten, cur_reg.rightCtrl,
                    cur_reg.leftCtrl, cur_reg.pwmSel, cur_reg.enable};

  // Rising edge of the line that drives the bridge latches direction
  assign pwmRise = (pwmLineA && !cur_reg.pwmAPrev)
                   || (mode == MODE_DUAL && pwmLineB && !cur_reg.pwmBPrev);

  // Requested gates, order {highL, lowL, highR, lowR}
  always_comb
  begin
    want = 4'h0;
    case (mode)
      MODE_DIRECT:
        want = {cur_reg.leftCtrl, !cur_reg.leftCtrl,
                cur_reg.rightCtrl, !cur_reg.rightCtrl};
      MODE_UP:
        if (!pwmLineA)
          want = 4'b1010;
        else if (!cur_reg.dirActive)
          want = 4'b1001;
        else
          want = 4'b0110;
      MODE_DOWN:
        if (!pwmLineA)
          want = 4'b0101;
        else if (!cur_reg.dirActive)
          want = 4'b1001;
        else
          want = 4'b0110;
      MODE_SYM:
        if (pwmLineA ^ cur_reg.dirActive)
          want = 4'b1001;
        else
          want = 4'b0110;
      MODE_DUAL:
        want = {pwmLineA, !pwmLineA, pwmLineB, !pwmLineB};
      default:
        want = 4'h0;
    endcase
    if (!cur_reg.enable || cur_reg.shortFlag || cur_reg.overheatFlag)
      want = 4'h0;
    want = want & ~cur_reg.swOff;
  end

  half_bridge_leg #(.DEAD(DEAD)) u_left (
    .mclk(mclk),
    .reset_n(reset_n),
    .wantHigh(want[3]),
    .wantLow(want[2]),
    .highSeenOn(gateSeenOn[3]),
    .lowSeenOn(gateSeenOn[2]),
    .gateHigh(gates[3]),
    .gateLow(gates[2])
  );

  half_bridge_leg #(.DEAD(DEAD)) u_right (
    .mclk(mclk),
    .reset_n(reset_n),
    .wantHigh(want[1]),
    .wantLow(want[0]),
    .highSeenOn(gateSeenOn[1]),
    .lowSeenOn(gateSeenOn[0]),
    .gateHigh(gates[1]),
    .gateLow(gates[0])
  );

  assign gateHighLeft = gates[3];
  assign gateLowLeft = gates[2];
  assign gateHighRight = gates[1];
  assign gateLowRight = gates[0];

  // Write takes address and data in either order
  assign wrAddr = cur_reg.awHeld ? cur_reg.awHeldAddr : awaddr;
  assign wrData = cur_reg.wHeld ? cur_reg.wHeldData : wdata;
  assign wrStrb = cur_reg.wHeld ? cur_reg.wHeldStrb : wstrb;
  assign doWrite = (cur_reg.awHeld || awvalid) && (cur_reg.wHeld || wvalid)
                   && !cur_reg.bValid;
  assign wrOk = addrHit(wrAddr);
  assign enClear = doWrite && wrOk && wrStrb[0]
                   && !wrData[`BIT_EN] && cur_reg.enable;
  assign anyOc = |perSwitchOvercurrent;

  assign awready = !cur_reg.awHeld && !cur_reg.bValid;
  assign wready = !cur_reg.wHeld && !cur_reg.bValid;
  assign arready = !cur_reg.rValid;

  always_comb
  begin
    cur_next = cur_reg;
    cur_next.pwmAPrev = pwmLineA;
    cur_next.pwmBPrev = pwmLineB;
    if (pwmRise)
      cur_next.dirActive = cur_reg.dirWritten;

    // Per-switch overcurrent: turn that switch off after the delay
    for (int i = 0; i < 4; i++)
    begin
      if (!perSwitchOvercurrent[i] || !cur_reg.enable)
        cur_next.ocCnt[i] = 8'h00;
      else if (cur_reg.ocCnt[i] < 8'(SHORT_OFF))
        cur_next.ocCnt[i] = cur_reg.ocCnt[i] + 8'h01;
      if (cur_reg.enable && perSwitchOvercurrent[i]
          && cur_reg.ocCnt[i] >= 8'(SHORT_OFF - 1))
        cur_next.swOff[i] = 1'b1;
    end

    // Bus channels
    if (awvalid && awready)
    begin
      cur_next.awHeld = 1'b1;
      cur_next.awHeldAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      cur_next.wHeld = 1'b1;
      cur_next.wHeldData = wdata;
      cur_next.wHeldStrb = wstrb;
    end
    if (doWrite)
    begin
      cur_next.awHeld = 1'b0;
      cur_next.wHeld = 1'b0;
      cur_next.bValid = 1'b1;
      cur_next.bResp = wrOk ? `RESP_OKAY : `RESP_SLVERR;
      if (wrOk && wrStrb[0])
      begin
        cur_next.enable = wrData[`BIT_EN];
        cur_next.pwmSel = wrData[`BIT_PWMSEL];
        cur_next.leftCtrl = wrData[`BIT_LEFT];
        cur_next.rightCtrl = wrData[`BIT_RIGHT];
        cur_next.dirWritten = wrData[`BIT_DIR];
        cur_next.irqEnable = wrData[`BIT_IRQEN];
        if (wrData[`BIT_IRQEN] && !cur_reg.irqEnable
            && (cur_reg.shortFlag || cur_reg.overheatFlag))
          cur_next.irq = 1'b1;
      end
    end
    if (cur_reg.bValid && bready)
      cur_next.bValid = 1'b0;

    if (arvalid && arready)
    begin
      cur_next.rValid = 1'b1;
      cur_next.rData = addrHit(araddr) ? {24'h0, csrView} : 32'h0;
      cur_next.rResp = addrHit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (cur_reg.rValid && rready)
      cur_next.rValid = 1'b0;

    // Fault flags; only hardware sets them, writes never do
    if (enClear)
    begin
      cur_next.shortFlag = 1'b0;
      cur_next.overheatFlag = 1'b0;
      cur_next.irq = 1'b0;
      cur_next.swOff = 4'h0;
    end
    else if (cur_reg.enable)
    begin
      if (anyOc)
        cur_next.shortFlag = 1'b1;
      if (overheatWarn)
        cur_next.overheatFlag = 1'b1;
      if (cur_next.irqEnable
          && ((anyOc && !cur_reg.shortFlag)
              || (overheatWarn && !cur_reg.overheatFlag)))
        cur_next.irq = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign bvalid = cur_reg.bValid;
  assign bresp = cur_reg.bResp;
  assign rvalid = cur_reg.rValid;
  assign rdata = cur_reg.rData;
  assign rresp = cur_reg.rResp;
  assign faultIrq = cur_reg.irq;

  a_off_disabled: assert property (@(posedge mclk)
    disable iff (!reset_n) !cur_reg.enable |-> gates == 4'h0)
    else $error("gate on while disabled");
  a_off_fault: assert property (@(posedge mclk) disable iff (!reset_n)
    (cur_reg.shortFlag || cur_reg.overheatFlag) |-> gates == 4'h0)
    else $error("gate on during fault");
  a_short_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (cur_reg.enable && anyOc && !enClear) |=> cur_reg.shortFlag)
    else $error("short flag not set");
  a_ovt_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (cur_reg.enable && overheatWarn && !enClear) |=> cur_reg.overheatFlag)
    else $error("overheat flag not set");
  a_clear_all: assert property (@(posedge mclk) disable iff (!reset_n)
    enClear |=> !cur_reg.shortFlag && !cur_reg.overheatFlag && !faultIrq)
    else $error("enable clear left state");
  a_irq_rise: assert property (@(posedge mclk) disable iff (!reset_n)
    (cur_reg.enable && cur_reg.irqEnable && !enClear && !doWrite
     && anyOc && !cur_reg.shortFlag) |=> faultIrq)
    else $error("no irq on short");
  a_dir_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !pwmRise |=> $stable(cur_reg.dirActive))
    else $error("direction changed without edge");
  a_dual_left: assert property (@(posedge mclk) disable iff (!reset_n)
    (mode == MODE_DUAL && cur_reg.enable && !cur_reg.shortFlag
     && !cur_reg.overheatFlag && cur_reg.swOff == 4'h0)
    |-> want[3:2] == {pwmLineA, !pwmLineA})
    else $error("dual mode left wrong");
  a_flag_ro: assert property (@(posedge mclk) disable iff (!reset_n)
    (!cur_reg.shortFlag && !(cur_reg.enable && anyOc)) |=> !cur_reg.shortFlag)
    else $error("short flag set by write");

  c_short: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(cur_reg.shortFlag));
  c_ovt_irq: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(faultIrq) && cur_reg.overheatFlag);
  c_dir: cover property (@(posedge mclk) disable iff (!reset_n)
    $changed(cur_reg.dirActive));
  c_sym: cover property (@(posedge mclk) disable iff (!reset_n)
    mode == MODE_SYM && gates != 4'h0);
endmodule

// ### bench/load_model.sv
// Load on the two bridge outputs: gate feedback and switch current.
// Assumes gates arrive as {high left, low left, high right, low right}.
`timescale 1ns/1ps

module load_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Gates, short command and feedback speed
  input wire logic [3:0] gates,
  input wire logic [3:0] shortCmd,
  input wire logic slow,
  // Sensed values
  output logic [3:0] gateSeenOn,
  output logic [3:0] perSwitchOvercurrent
);
  logic [3:0] seen1, seen2, seen3;

  // Gate voltage lags the drive by one or three cycles
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seen1 <= 4'h0;
      seen2 <= 4'h0;
      seen3 <= 4'h0;
    end
    else
    begin
      seen1 <= gates;
      seen2 <= seen1;
      seen3 <= seen2;
    end
  end
  assign gateSeenOn = slow ? seen3 : seen1;
  // A short only draws current through a conducting switch
  assign perSwitchOvercurrent = shortCmd & gateSeenOn;
endmodule

// ### bench/hbridge_drive_protect_tb.sv
// Testbench for the H-bridge drive and protection block.
// Assumes an AXI4-Lite master here and a load model on the gates.
`timescale 1ns/1ps
`include "bridge_params.svh"

module hbridge_drive_protect_tb;
  import bridge_pkg::*;
  localparam int SOFF = 4;
  localparam int DT = 2;
  localparam logic [31:0] CSR_BA = 32'({`CSR_ADDR, 2'b00});
  logic mclk, reset_n, slow;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] wstrb, perSwitchOvercurrent, gateSeenOn, shortCmd, gates;
  logic [1:0] bresp, rresp, rsp;
  logic pwmLineA, pwmLineB, overheatWarn, faultIrq;
  logic gateHighLeft, gateLowLeft, gateHighRight, gateLowRight;
  logic [7:0] cb, fb;
  int error_cnt, checked;

  assign gates = {gateHighLeft, gateLowLeft, gateHighRight, gateLowRight};

  hbridge_drive_protect #(.SHORT_OFF(SOFF), .DEAD(DT)) hbridge_drive_protect_i (
    .mclk(mclk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pwmLineA(pwmLineA),
    .pwmLineB(pwmLineB), .perSwitchOvercurrent(perSwitchOvercurrent),
    .overheatWarn(overheatWarn), .gateSeenOn(gateSeenOn),
    .gateHighLeft(gateHighLeft), .gateLowLeft(gateLowLeft),
    .gateHighRight(gateHighRight), .gateLowRight(gateLowRight),
    .faultIrq(faultIrq));

  load_model load_model_i (
    .mclk(mclk), .reset_n(reset_n), .gates(gates), .shortCmd(shortCmd),
    .slow(slow), .gateSeenOn(gateSeenOn),
    .perSwitchOvercurrent(perSwitchOvercurrent));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 200)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      tick(n);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rsp = bresp;
  endtask

  task automatic rdw(input logic [31:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      tick(n);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rsp = rresp;
  endtask

  task automatic wc(input logic [7:0] d);
    wr(CSR_BA, {24'h0, d});
    check("write response", {30'h0, rsp}, {30'h0, `RESP_OKAY});
  endtask

  task automatic rc(input logic [7:0] e);
    rdw(CSR_BA);
    check("control status", rd, {24'h0, e});
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic gchk(input logic [3:0] e);
    waitc(DT + 10);
    check("gates", {28'h0, gates}, {28'h0, e});
  endtask

  task automatic setPwm(input logic a, input logic b);
    pwmLineA <= a;
    pwmLineB <= b;
  endtask

  // Expected {high left, low left, high right, low right} in PWM modes
  function automatic logic [3:0] gx(input int k, input logic d, a, b);
    case (k)
      0: return a ? (d ? 4'h6 : 4'h9) : 4'ha;
      1: return a ? (d ? 4'h6 : 4'h9) : 4'h5;
      2: return (d ^ a) ? 4'h9 : 4'h6;
      default: return {a, ~a, b, ~b};
    endcase
  endfunction

  // No half bridge may ever conduct through both switches
  always @(negedge mclk)
    if (reset_n === 1'b1)
      check("overlap", {30'h0, gateHighLeft & gateLowLeft,
        gateHighRight & gateLowRight}, 32'h0);

  initial
  begin
    {awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
    {pwmLineA, pwmLineB, overheatWarn, shortCmd} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    slow = 1'b1;
    reset_n = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rc(8'h00);
    gchk(4'h0);
    rdw(32'h0);
    check("read response", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    check("unmapped data", rd, 32'h0);
    wr(32'h0, 32'hff);
    check("write response", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    rc(8'h00);
    wc(8'h21);
    rc(8'h01);
    for (int k = 0; k < 4; k++)
    begin
      wc({4'h0, k[1], k[0], 2'b01});
      gchk({k[0], ~k[0], k[1], ~k[1]});
    end
    wc(8'h00);
    gchk(4'h0);
    slow <= 1'b0;
    for (int k = 0; k < 4; k++)
      for (int d = 0; d < 2; d++)
      begin
        setPwm(1'b0, 1'b0);
        wc({3'h0, d[0], k[0], k[1], 2'b11});
        setPwm(1'b1, 1'b1);
        gchk(gx(k, d[0], 1'b1, 1'b1));
        setPwm(1'b0, 1'b1);
        gchk(gx(k, d[0], 1'b0, 1'b1));
        setPwm(1'b1, 1'b0);
        gchk(gx(k, d[0], 1'b1, 1'b0));
      end
    setPwm(1'b0, 1'b0);
    wc(8'h07);
    setPwm(1'b1, 1'b0);
    gchk(4'h9);
    wc(8'h17);
    gchk(4'h9);
    setPwm(1'b0, 1'b0);
    gchk(4'h6);
    setPwm(1'b1, 1'b0);
    gchk(4'h6);
    for (int j = 0; j < 5; j++)
    begin
      fb = (j == 4) ? 8'h40 : 8'h20;
      cb = 8'h81 | {4'h0, j[0], j[0], 2'b00};
      wc(cb);
      waitc(DT + 6);
      if (j == 4)
        overheatWarn <= 1'b1;
      else
        shortCmd[j] <= 1'b1;
      waitc(SOFF + 4);
      check("irq", {31'h0, faultIrq}, 32'h1);
      gchk(4'h0);
      rc(cb | fb);
      wc(cb);
      gchk(4'h0);
      rc(cb | fb);
      shortCmd <= 4'h0;
      wc(8'h80);
      check("irq", {31'h0, faultIrq}, 32'h0);
      rc(8'h80);
    end
    wc(8'h01);
    waitc(4);
    rc(8'h41);
    check("irq", {31'h0, faultIrq}, 32'h0);
    wc(8'h81);
    check("irq", {31'h0, faultIrq}, 32'h1);
    overheatWarn <= 1'b0;
    wc(8'h00);
    check("irq", {31'h0, faultIrq}, 32'h0);
    rc(8'h00);
    wc(8'h0d);
    waitc(4);
    reset_n <= 1'b0;
    waitc(2);
    reset_n <= 1'b1;
    waitc(1);
    rc(8'h00);
    gchk(4'h0);
    end_of_test();
  end
endmodule
